//--- core/nvsram_host_ctrl.sv
// host controller driving the pins of a byte-wide nonvolatile SRAM
// Notes on behaviour
// - host holds address stable from before write until select or strobe rises
// - host keeps output gate high during writes
// - host keeps write strobe high whenever select low in the sequence
// - each sequence step is one select low pulse; host toggles select
// - sequence is 0000,1555,0AAA,1FFF,10F0 then 0F0F store or 0F0E recall
// - external busy low pulse over minimum width starts conditional STORE
`timescale 1ns/1ps
`include "nvsram_host_regs.svh"
module nvsram_host_ctrl
   import nvsram_host_pkg::*;
#(
   parameter int STORE_CYC  = `STORE_CYC,
   parameter int RECALL_CYC = `RECALL_CYC
) (
   input  wire logic                  SYS_CLK,
   input  wire logic                  RESET,
   input  wire logic                  CMD_VALID,
   input  wire op_e                   CMD_OP,
   input  wire logic [`NV_ADDR_W-1:0] CMD_ADDR,
   input  wire logic [`NV_DATA_W-1:0] CMD_WDATA,
   output logic                       CMD_READY,
   output logic                       CMD_DONE,
   output logic      [`NV_DATA_W-1:0] RD_DATA,
   output logic      [`NV_ADDR_W-1:0] ADDRESS_INPUTS,
   output logic                       NV_CS_N,
   output logic                       NV_WE_N,
   output logic                       NV_OE_N,
   input  wire logic [`NV_DATA_W-1:0] DATA_LINES_I,
   output logic      [`NV_DATA_W-1:0] DATA_LINES_O,
   output logic                       DATA_LINES_OE,
   input  wire logic                  STORE_BUSY_LINE_I,
   output logic                       STORE_BUSY_LINE_O,
   output logic                       STORE_BUSY_LINE_OE
);
   // strobe held long enough for a full access plus the input synchroniser
   localparam timer_t STROBE_T      = timer_t'(`ACCESS_CYC + `SYNC_STAGES - 1);
   localparam timer_t PULSE_T       = timer_t'(`HSB_PULSE_CYC);
   localparam timer_t INHIBIT_ON_T  = timer_t'(`INHIBIT_ON_CYC);
   localparam timer_t INHIBIT_OFF_T = timer_t'(`INHIBIT_OFF_CYC - 1);
   localparam timer_t STORE_T       = timer_t'(STORE_CYC);
   localparam timer_t RECALL_T      = timer_t'(RECALL_CYC);

   ctl_s  ctl_reg;
   ctl_s  ctl_next;
   data_t dq_sync;
   logic  busy_sync;

   function automatic addr_t seq_addr(input logic [2:0] idx, input op_e op);
      unique case (idx)
         3'h0:    seq_addr = `SEQ_ADDR_0;
         3'h1:    seq_addr = `SEQ_ADDR_1;
         3'h2:    seq_addr = `SEQ_ADDR_2;
         3'h3:    seq_addr = `SEQ_ADDR_3;
         3'h4:    seq_addr = `SEQ_ADDR_4;
         default: seq_addr = (op == OP_SW_RECALL) ? `SEQ_ADDR_RECALL
                                                  : `SEQ_ADDR_STORE;
      endcase
   endfunction : seq_addr

   function automatic logic is_seq(input op_e op);
      is_seq = (op == OP_SW_STORE) || (op == OP_SW_RECALL);
   endfunction : is_seq

   nv_sync2 #(.W(`NV_DATA_W), .RESET_VAL(8'h00)) u_dq_sync (
      .SYS_CLK (SYS_CLK),
      .RESET   (RESET),
      .din     (DATA_LINES_I),
      .dout    (dq_sync)
   );

   // busy resets as low so nothing is issued before the line is really seen high
   nv_sync2 #(.W(1), .RESET_VAL(1'h0)) u_busy_sync (
      .SYS_CLK (SYS_CLK),
      .RESET   (RESET),
      .din     (STORE_BUSY_LINE_I),
      .dout    (busy_sync)
   );

   always_comb begin
      ctl_next      = ctl_reg;
      ctl_next.done = 1'b0;
      unique case (ctl_reg.state)
         S_IDLE: begin
            // a low busy line means the device is disabled; wait it out
            if (CMD_VALID && ctl_reg.ready) begin
               ctl_next.op      = CMD_OP;
               ctl_next.wdata   = CMD_WDATA;
               ctl_next.seq_idx = 3'h0;
               unique case (CMD_OP)
                  OP_HW_STORE: begin
                     ctl_next.state   = S_PULSE;
                     ctl_next.busy_oe = 1'b1;
                     ctl_next.timer   = PULSE_T;
                  end
                  OP_SW_STORE, OP_SW_RECALL: begin
                     ctl_next.state = S_SETUP;
                     ctl_next.addr  = seq_addr(3'h0, CMD_OP);
                  end
                  default: begin
                     ctl_next.state = S_SETUP;
                     ctl_next.addr  = CMD_ADDR;
                  end
               endcase
            end
         end
         S_SETUP: begin
            // address has stood one cycle with select high before the strobe
            ctl_next.state = S_STROBE;
            ctl_next.timer = STROBE_T;
            ctl_next.cs_n  = 1'b0;
            if (ctl_reg.op == OP_WRITE) begin
               ctl_next.we_n  = 1'b0;
               ctl_next.oe_n  = 1'b1;
               ctl_next.dq_oe = 1'b1;
            end else begin
               ctl_next.we_n  = 1'b1;
               ctl_next.oe_n  = 1'b0;
               ctl_next.dq_oe = 1'b0;
            end
         end
         S_STROBE: begin
            if (ctl_reg.timer == '0) begin
               if (ctl_reg.op != OP_WRITE) begin
                  ctl_next.rdata = dq_sync;
               end
               ctl_next.state = S_HOLD;
               ctl_next.cs_n  = 1'b1;
               ctl_next.we_n  = 1'b1;
               ctl_next.oe_n  = 1'b1;
            end else begin
               ctl_next.timer = ctl_reg.timer - timer_t'(1);
            end
         end
         S_HOLD: begin
            // address and data held one cycle past the rising strobe
            ctl_next.dq_oe = 1'b0;
            if (is_seq(ctl_reg.op) && ctl_reg.seq_idx != `SEQ_LAST_IDX) begin
               // steps go back to back so no other access can break the run
               ctl_next.seq_idx = ctl_reg.seq_idx + 3'h1;
               ctl_next.addr    = seq_addr(ctl_reg.seq_idx + 3'h1, ctl_reg.op);
               ctl_next.state   = S_SETUP;
            end else if (is_seq(ctl_reg.op)) begin
               ctl_next.state = S_WAIT_NV;
               ctl_next.timer = (ctl_reg.op == OP_SW_RECALL) ? RECALL_T
                                                            : STORE_T;
            end else begin
               ctl_next.state = S_IDLE;
               ctl_next.done  = 1'b1;
            end
         end
         S_PULSE: begin
            if (ctl_reg.timer == '0) begin
               ctl_next.busy_oe = 1'b0;
               ctl_next.state   = S_WAIT_NV;
               ctl_next.timer   = INHIBIT_ON_T;
            end else begin
               ctl_next.timer = ctl_reg.timer - timer_t'(1);
            end
         end
         S_WAIT_NV: begin
            // fixed wait first, then the busy line must read high again
            if (ctl_reg.timer != '0) begin
               ctl_next.timer = ctl_reg.timer - timer_t'(1);
            end else if (busy_sync) begin
               ctl_next.state = S_RECOVER;
               ctl_next.timer = INHIBIT_OFF_T;
            end
         end
         S_RECOVER: begin
            if (ctl_reg.timer == '0) begin
               ctl_next.state = S_IDLE;
               ctl_next.done  = 1'b1;
            end else begin
               ctl_next.timer = ctl_reg.timer - timer_t'(1);
            end
         end
         default: begin
            ctl_next.state = S_IDLE;
         end
      endcase
      ctl_next.ready = (ctl_next.state == S_IDLE) && busy_sync;
   end

   always_ff @(posedge SYS_CLK) begin
      if (RESET) begin
         ctl_reg <= '{state: S_IDLE, op: OP_READ, timer: '0, seq_idx: 3'h0,
                      addr: '0, wdata: '0, rdata: '0, cs_n: 1'b1, we_n: 1'b1,
                      oe_n: 1'b1, dq_oe: 1'b0, busy_oe: 1'b0, ready: 1'b0,
                      done: 1'b0};
      end else begin
         ctl_reg <= ctl_next;
      end
   end

   assign CMD_READY          = ctl_reg.ready;
   assign CMD_DONE           = ctl_reg.done;
   assign RD_DATA            = ctl_reg.rdata;
   assign ADDRESS_INPUTS     = ctl_reg.addr;
   assign NV_CS_N            = ctl_reg.cs_n;
   assign NV_WE_N            = ctl_reg.we_n;
   assign NV_OE_N            = ctl_reg.oe_n;
   assign DATA_LINES_O       = ctl_reg.wdata;
   assign DATA_LINES_OE      = ctl_reg.dq_oe;
   // open drain: only ever pulls low
   assign STORE_BUSY_LINE_O  = 1'b0;
   assign STORE_BUSY_LINE_OE = ctl_reg.busy_oe;

endmodule : nvsram_host_ctrl

//--- include/nvsram_host_regs.svh
// timing counts, pin widths and sequence addresses for the nvSRAM host controller
`ifndef NVSRAM_HOST_REGS_SVH
`define NVSRAM_HOST_REGS_SVH

`define NV_ADDR_W            13
`define NV_DATA_W            8
`define NV_TIMER_W           24

`define CLK_PERIOD_NS        10
// least times round up, all at least one cycle
`define T_ACCESS_NS          25
`define T_HSB_PULSE_NS       250
`define T_INHIBIT_ON_NS      1000
`define T_INHIBIT_OFF_NS     700
`define T_STORE_US           10000
`define T_RECALL_US          20
`define CYC_UP(ns)           (((ns) + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define ACCESS_CYC           `CYC_UP(`T_ACCESS_NS)
`define HSB_PULSE_CYC        `CYC_UP(`T_HSB_PULSE_NS)
`define INHIBIT_ON_CYC       `CYC_UP(`T_INHIBIT_ON_NS)
`define INHIBIT_OFF_CYC      `CYC_UP(`T_INHIBIT_OFF_NS)
`define STORE_CYC            `CYC_UP(`T_STORE_US * 1000)
`define RECALL_CYC           `CYC_UP(`T_RECALL_US * 1000)
`define SYNC_STAGES          2

`define SEQ_ADDR_0           13'h0000
`define SEQ_ADDR_1           13'h1555
`define SEQ_ADDR_2           13'h0AAA
`define SEQ_ADDR_3           13'h1FFF
`define SEQ_ADDR_4           13'h10F0
`define SEQ_ADDR_STORE       13'h0F0F
`define SEQ_ADDR_RECALL      13'h0F0E
`define SEQ_LAST_IDX         3'h5

`endif

//--- include/nvsram_host_pkg.sv
// types shared by the nvSRAM host controller
package nvsram_host_pkg;
`include "nvsram_host_regs.svh"

   typedef logic [`NV_ADDR_W-1:0]  addr_t;
   typedef logic [`NV_DATA_W-1:0]  data_t;
   typedef logic [`NV_TIMER_W-1:0] timer_t;

   typedef enum logic [2:0] {
      OP_READ      = 3'h0,
      OP_WRITE     = 3'h1,
      OP_SW_STORE  = 3'h2,
      OP_SW_RECALL = 3'h3,
      OP_HW_STORE  = 3'h4
   } op_e;

   typedef enum logic [6:0] {
      S_IDLE    = 7'h01,
      S_SETUP   = 7'h02,
      S_STROBE  = 7'h04,
      S_HOLD    = 7'h08,
      S_PULSE   = 7'h10,
      S_WAIT_NV = 7'h20,
      S_RECOVER = 7'h40
   } state_e;

   typedef struct packed {
      state_e     state;
      op_e        op;
      timer_t     timer;
      logic [2:0] seq_idx;
      addr_t      addr;
      data_t      wdata;
      data_t      rdata;
      logic       cs_n;
      logic       we_n;
      logic       oe_n;
      logic       dq_oe;
      logic       busy_oe;
      logic       ready;
      logic       done;
   } ctl_s;

endpackage : nvsram_host_pkg

//--- core/nv_sync2.sv
// two-flop synchroniser for pins arriving from outside the clock domain
`timescale 1ns/1ps
module nv_sync2 #(
   parameter int            W         = 1,
   parameter logic [W-1:0]  RESET_VAL = '0
) (
   input  wire logic         SYS_CLK,
   input  wire logic         RESET,
   input  wire logic [W-1:0] din,
   output logic      [W-1:0] dout
);
   logic [W-1:0] meta_reg;

   always_ff @(posedge SYS_CLK) begin
      if (RESET) begin
         meta_reg <= RESET_VAL;
         dout     <= RESET_VAL;
      end else begin
         meta_reg <= din;
         dout     <= meta_reg;
      end
   end
endmodule : nv_sync2

//--- bench/nvsram_host_ctrl_monitor.sv
// pin-level checks of the nvSRAM host controller
`timescale 1ns/1ps
`include "nvsram_host_regs.svh"
module nvsram_host_ctrl_monitor
   import nvsram_host_pkg::*;
(
   input wire logic                  SYS_CLK,
   input wire logic                  RESET,
   input wire logic                  CMD_VALID,
   input wire op_e                   CMD_OP,
   input wire logic                  CMD_READY,
   input wire logic                  CMD_DONE,
   input wire logic [`NV_ADDR_W-1:0] ADDRESS_INPUTS,
   input wire logic                  NV_CS_N,
   input wire logic                  NV_WE_N,
   input wire logic                  NV_OE_N,
   input wire logic                  DATA_LINES_OE,
   input wire logic                  STORE_BUSY_LINE_I,
   input wire logic                  STORE_BUSY_LINE_OE
);
   default clocking @(posedge SYS_CLK); endclocking
   default disable iff (RESET);
   logic seq_reg;
   logic seq_next;
   wire  take = CMD_VALID && CMD_READY;
   // flag spans take to done; ops never overlap on this port
   always_comb begin
      seq_next = CMD_DONE ? 1'b0 : seq_reg;
      if (take) seq_next = CMD_OP == OP_SW_STORE || CMD_OP == OP_SW_RECALL;
   end
   always_ff @(posedge SYS_CLK) seq_reg <= RESET ? 1'b0 : seq_next;
   a_seq_strobe_high: assert property (seq_reg && !NV_CS_N |-> NV_WE_N)
      else $error("write strobe low inside sequence");
   a_write_gate_high: assert property (!NV_WE_N |-> NV_OE_N)
      else $error("output gate low during write");
   a_write_addr_hold: assert property (!NV_WE_N |-> $stable(ADDRESS_INPUTS))
      else $error("address moved during write");
   a_write_drives: assert property (!NV_WE_N |-> !NV_CS_N && DATA_LINES_OE)
      else $error("write strobe without select or data");
   a_select_width: assert property ($fell(NV_CS_N) |-> !NV_CS_N [*5] ##1 NV_CS_N)
      else $error("select pulse not five cycles");
   a_rw_done_lat: assert property (take && CMD_OP inside {OP_READ, OP_WRITE} |-> ##8 CMD_DONE)
      else $error("read or write done not eight cycles after take");
   a_take_busy: assert property (take |=> !CMD_READY)
      else $error("ready stayed high after take");
   a_busy_blocks: assert property (!STORE_BUSY_LINE_I [*3] |=> !CMD_READY)
      else $error("ready high while busy line low");
   a_pin_pulse: assert property ($rose(STORE_BUSY_LINE_OE) |-> STORE_BUSY_LINE_OE [*8] ##18 STORE_BUSY_LINE_OE)
      else $error("busy pulse shorter than 26 cycles");
   c_read: cover property (take && CMD_OP == OP_READ);
   c_store: cover property (take && CMD_OP == OP_SW_STORE);
   c_pin: cover property ($rose(STORE_BUSY_LINE_OE));
   c_recall: cover property (take && CMD_OP == OP_SW_RECALL);
endmodule : nvsram_host_ctrl_monitor
bind nvsram_host_ctrl nvsram_host_ctrl_monitor mon (.SYS_CLK, .RESET, .CMD_VALID, .CMD_OP,
   .CMD_READY, .CMD_DONE, .ADDRESS_INPUTS, .NV_CS_N, .NV_WE_N, .NV_OE_N, .DATA_LINES_OE,
   .STORE_BUSY_LINE_I, .STORE_BUSY_LINE_OE);

//--- bench/nv_device_model.sv
// behavioural model of the nonvolatile SRAM on the host pins
`timescale 1ns/1ps
`include "nvsram_host_regs.svh"
module nv_device_model
   import nvsram_host_pkg::*;
#(
   parameter int STORE_T  = 40,
   parameter int RECALL_T = 15,
   parameter int PULSE_T  = 20
) (
   input  wire logic  clk,
   input  wire addr_t addr,
   input  wire logic  cs_n,
   input  wire logic  we_n,
   input  wire logic  oe_n,
   input  wire data_t dq_in,
   output data_t      dq_out,
   input  wire logic  busy_in,
   output logic       busy_pull
);
   data_t mem [8192];
   data_t nv [8192];
   data_t last = 8'h00;
   logic  dirty = 1'b0;
   logic  cs_q = 1'b1;
   logic  wr_seen = 1'b0;
   logic  ok;
   logic  supply_low = 1'b0;
   int    t_busy = 0, t_rec = 0, low_cnt = 0, step = 0, store_cnt = 0, recall_cnt = 0;
   addr_t seq [5] = '{`SEQ_ADDR_0, `SEQ_ADDR_1, `SEQ_ADDR_2, `SEQ_ADDR_3, `SEQ_ADDR_4};
   // array transfers are instant; only the disabled window is timed
   assign ok = busy_in && t_busy == 0 && t_rec == 0;
   // released lines show the inverse of the last value, not a stale byte
   assign dq_out = (!cs_n && !oe_n && we_n && ok) ? mem[addr] : ~last;
   initial begin
      busy_pull = 1'b0;
      nv = '{default: 8'h00};
      mem = nv;
   end
   always @(posedge clk) begin
      last <= dq_out;
      if (t_busy == 1) begin
         nv = mem;
         dirty = 1'b0;
         store_cnt++;
      end
      if (t_rec == 1) begin
         mem = nv;
         recall_cnt++;
      end
      if (t_busy > 0) t_busy--;
      if (t_rec > 0) t_rec--;
      low_cnt = (busy_in || busy_pull) ? 0 : low_cnt + 1;
      if (low_cnt == PULSE_T && dirty) t_busy = STORE_T;
      if (supply_low && dirty && t_busy == 0) t_busy = STORE_T;
      if (!cs_n && !we_n && ok) begin
         mem[addr] = dq_in;
         dirty = 1'b1;
         wr_seen = 1'b1;
      end
      if (!cs_q && cs_n && ok) begin
         if (!wr_seen && step < 5 && addr == seq[step]) step++;
         else begin
            if (!wr_seen && step == 5 && addr == `SEQ_ADDR_STORE) t_busy = STORE_T;
            if (!wr_seen && step == 5 && addr == `SEQ_ADDR_RECALL) t_rec = RECALL_T;
            step = (!wr_seen && addr == `SEQ_ADDR_0) ? 1 : 0;
         end
         wr_seen = 1'b0;
      end
      // nonblocking so the host synchroniser never races the pull on this edge
      busy_pull <= t_busy != 0;
      cs_q = cs_n;
   end
endmodule : nv_device_model

//--- bench/tb_nvsram_host_ctrl.sv
// self-checking bench of the nvSRAM host controller against the device model
`timescale 1ns/1ps
`include "nvsram_host_regs.svh"
module tb_nvsram_host_ctrl
   import nvsram_host_pkg::*;
;
   logic  SYS_CLK = 1'b0;
   logic  RESET = 1'b1;
   logic  CMD_VALID = 1'b0;
   op_e   CMD_OP = OP_READ;
   addr_t CMD_ADDR = 13'h0000;
   data_t CMD_WDATA = 8'h00;
   logic  CMD_READY, CMD_DONE, NV_CS_N, NV_WE_N, NV_OE_N, DATA_LINES_OE, STORE_BUSY_LINE_OE;
   logic  STORE_BUSY_LINE_I, busy_pull;
   data_t RD_DATA, DATA_LINES_I, DATA_LINES_O, dq_dev;
   addr_t ADDRESS_INPUTS;
   int    errors = 0;
   int    compares = 0;
   // short store and recall counts keep the run brief
   nvsram_host_ctrl #(.STORE_CYC(50), .RECALL_CYC(20)) uut (.SYS_CLK, .RESET, .CMD_VALID,
      .CMD_OP, .CMD_ADDR, .CMD_WDATA, .CMD_READY, .CMD_DONE, .RD_DATA, .ADDRESS_INPUTS,
      .NV_CS_N, .NV_WE_N, .NV_OE_N, .DATA_LINES_I, .DATA_LINES_O, .DATA_LINES_OE,
      .STORE_BUSY_LINE_I, .STORE_BUSY_LINE_O(), .STORE_BUSY_LINE_OE);
   nv_device_model dev (.clk(SYS_CLK), .addr(ADDRESS_INPUTS), .cs_n(NV_CS_N), .we_n(NV_WE_N),
      .oe_n(NV_OE_N), .dq_in(DATA_LINES_I), .dq_out(dq_dev), .busy_in(STORE_BUSY_LINE_I),
      .busy_pull(busy_pull));
   assign DATA_LINES_I = DATA_LINES_OE ? DATA_LINES_O : dq_dev;
   // open-drain busy line with pull-up
   assign STORE_BUSY_LINE_I = !(STORE_BUSY_LINE_OE || busy_pull);
   initial begin
      forever #5 SYS_CLK = ~SYS_CLK;
   end
   task automatic conclude;
      $display("compares %0d errors %0d", compares, errors);
      if (errors == 0 && compares > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask : conclude
   task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
      compares++;
      if (seen !== exp) begin
         errors++;
         $display("mismatch %s expected %0h seen %0h", what, exp, seen);
      end
   endtask : check
   task automatic run(input op_e op, input addr_t a, input data_t d);
      int n;
      n = 0;
      @(negedge SYS_CLK);
      CMD_VALID = 1'b1;
      CMD_OP = op;
      CMD_ADDR = a;
      CMD_WDATA = d;
      while (CMD_READY !== 1'b1 && n < 200) begin
         @(negedge SYS_CLK);
         n++;
      end
      @(negedge SYS_CLK);
      CMD_VALID = 1'b0;
      while (CMD_DONE !== 1'b1 && n < 800) begin
         @(negedge SYS_CLK);
         n++;
      end
      if (CMD_DONE !== 1'b1) begin
         errors++;
         conclude();
      end
   endtask : run
   task automatic sc_write_read;
      run(OP_WRITE, 13'h0000, 8'hA5);
      run(OP_WRITE, 13'h1FFF, 8'h3C);
      run(OP_READ, 13'h0000, 8'h00);
      check("rd_0000", RD_DATA, 8'hA5);
      run(OP_READ, 13'h1FFF, 8'h00);
      check("rd_1fff", RD_DATA, 8'h3C);
   endtask : sc_write_read
   task automatic sc_sw_store;
      int n;
      n = dev.store_cnt;
      run(OP_SW_STORE, 13'h0000, 8'h00);
      check("store_cnt", dev.store_cnt, n + 1);
      check("dirty", dev.dirty, 1'b0);
      run(OP_SW_STORE, 13'h0000, 8'h00);
      check("clean_store", dev.store_cnt, n + 2);
   endtask : sc_sw_store
   task automatic sc_pin_store;
      int n;
      n = dev.store_cnt;
      run(OP_HW_STORE, 13'h0000, 8'h00);
      check("pin_skip", dev.store_cnt, n);
      run(OP_WRITE, 13'h1555, 8'h0F);
      run(OP_HW_STORE, 13'h0000, 8'h00);
      check("pin_store", dev.store_cnt, n + 1);
   endtask : sc_pin_store
   task automatic sc_recall;
      int n;
      run(OP_WRITE, 13'h0AAA, 8'h5A);
      run(OP_SW_STORE, 13'h0000, 8'h00);
      run(OP_WRITE, 13'h0AAA, 8'h77);
      run(OP_READ, 13'h0AAA, 8'h00);
      check("rd_new", RD_DATA, 8'h77);
      n = dev.store_cnt;
      run(OP_SW_RECALL, 13'h0000, 8'h00);
      check("no_store", dev.store_cnt, n);
      run(OP_READ, 13'h0AAA, 8'h00);
      check("rd_recalled", RD_DATA, 8'h5A);
   endtask : sc_recall
   task automatic sc_power_fail;
      int n;
      run(OP_WRITE, 13'h10F0, 8'hC3);
      n = dev.store_cnt;
      @(negedge SYS_CLK);
      dev.supply_low = 1'b1;
      repeat (10) @(negedge SYS_CLK);
      check("ready_blocked", CMD_READY, 1'b0);
      repeat (50) @(negedge SYS_CLK);
      dev.supply_low = 1'b0;
      check("auto_store", dev.store_cnt, n + 1);
      run(OP_READ, 13'h10F0, 8'h00);
      check("rd_after_fail", RD_DATA, 8'hC3);
   endtask : sc_power_fail
   initial begin
      repeat (3) @(negedge SYS_CLK);
      RESET = 1'b0;
      sc_write_read();
      sc_sw_store();
      sc_pin_store();
      sc_recall();
      sc_power_fail();
      conclude();
   end
endmodule : tb_nvsram_host_ctrl
